// ### cla_pkg.sv
// shared constants and carry helper functions for the lookahead adder
package cla_pkg;

    // bits handled by one add or subtract slice
    localparam int SLICE_BITS = 3;
    // longest chain of lookahead stages the carry network supports
    localparam int MAX_STAGES = 4;
    // default operand width: four slices plus two leftover bits
    localparam int DEFAULT_WIDTH = 14;
    // value of the registered carry or borrow after reset
    localparam logic CARRY_RESET = 1'b0;

    // carry out of a slice, built without the incoming carry
    function automatic logic group_generate(
        input logic [SLICE_BITS-1:0] gen,
        input logic [SLICE_BITS-1:0] prop
    );
        group_generate = gen[2] | (prop[2] & gen[1])
            | (prop[2] & prop[1] & gen[0]);
    endfunction

    // flat sum of products for the carry out of stage k (0 based)
    function automatic logic lookahead_carry(
        input logic [MAX_STAGES-1:0] g,
        input logic [MAX_STAGES-1:0] p,
        input logic cin,
        input int k
    );
        logic acc;
        logic term;
        acc = cin;
        term = 1'b0;
        // the product term that carries the initial carry
        for (int i = 0; i <= k; i++)
        begin
            acc = acc & p[i];
        end
        // one product term per generating stage
        for (int j = 0; j <= k; j++)
        begin
            term = g[j];
            for (int m = j + 1; m <= k; m++)
            begin
                term = term & p[m];
            end
            acc = acc | term;
        end
        lookahead_carry = acc;
    endfunction

endpackage

// ### slice_if.sv
// signals between the top level and one three bit slice
`timescale 1ns/10ps
`default_nettype none
interface slice_if;
    import cla_pkg::*;
    logic [SLICE_BITS-1:0] a; // first operand bits
    logic [SLICE_BITS-1:0] b; // second operand bits
    logic cin; // carry or borrow into the slice
    logic subtract; // high selects the borrow form
    logic [SLICE_BITS-1:0] sum; // sum or difference bits
    logic [SLICE_BITS-1:0] bit_gen; // per bit generate
    logic [SLICE_BITS-1:0] bit_prop; // per bit propagate
    logic gp; // single group propagate
    logic gg; // group generate
    modport driver (
        output a, b, cin, subtract,
        input sum, bit_gen, bit_prop, gp, gg
    );
    modport slice (
        input a, b, cin, subtract,
        output sum, bit_gen, bit_prop, gp, gg
    );
endinterface
`default_nettype wire

// ### three_bit_add_slice.sv
// three bit add or subtract slice with group propagate and generate
`timescale 1ns/10ps
`default_nettype none
module three_bit_add_slice (
    slice_if.slice port
);
    import cla_pkg::*;

    logic [SLICE_BITS-1:0] x; // first operand, inverted for borrow
    logic [SLICE_BITS:0] c; // internal carries, c[0] is the input

    // borrow form: inverting the minuend turns borrow into carry logic
    always_comb
    begin
        x = port.subtract ? ~port.a : port.a;
        c[0] = port.cin;
        for (int i = 0; i < SLICE_BITS; i++)
        begin
            c[i+1] = (x[i] & port.b[i]) | ((x[i] | port.b[i]) & c[i]);
        end
    end

    assign port.bit_gen = x & port.b;
    assign port.bit_prop = x | port.b;
    // difference bits equal sum bits: a ^ b ^ borrow
    assign port.sum = port.a ^ port.b ^ c[SLICE_BITS-1:0];
    // one propagate for the whole slice, raised by any set bit
    assign port.gp = |(x | port.b);
    // carry out of the top bit without the incoming carry
    assign port.gg = group_generate(x & port.b, x | port.b);
endmodule
`default_nettype wire

// ### carry_lookahead_add_sub.sv
// carry lookahead adder and subtractor built from three bit slices
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - bit generate is a and b
// - bit propagate is a or b
// - stage carry is flat sum of products
// - two logic levels per lookahead carry
// - slice adds three bits, outputs group signals
// - single group propagate from any set bit
// - group generate ignores incoming carry
// - first stage: generate, or propagate and carry
// - second stage expands over two slices
// - stage inputs wired from matching slices
// - six bits: carry out from second stage
// - leftover bits use plain adder, lookahead carry
// - subtract mode uses borrow through same stages
module carry_lookahead_add_sub #(
    parameter int WIDTH = cla_pkg::DEFAULT_WIDTH // at most 14 bits
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [WIDTH-1:0] operand_a,
    input wire logic [WIDTH-1:0] operand_b,
    input wire logic initial_carry_in,
    input wire logic subtract,
    output var logic [WIDTH-1:0] result_q,
    output var logic carry_out_q
);
    import cla_pkg::*;

    // slice count and leftover bits follow from the width
    localparam int NUM_SLICES = WIDTH / SLICE_BITS;
    localparam int REM_BITS = WIDTH - NUM_SLICES * SLICE_BITS;

    logic [MAX_STAGES-1:0] g_all; // group generates, zero padded
    logic [MAX_STAGES-1:0] p_all; // group propagates, zero padded
    logic [NUM_SLICES:0] carry; // carry or borrow into each slice
    logic [WIDTH-1:0] sum_comb; // unregistered result
    logic cout_comb; // unregistered carry or borrow out
    logic [WIDTH-1:0] result_d;
    logic carry_out_d;

    // in subtract mode the input is a borrow
    assign carry[0] = initial_carry_in;

    genvar s;
    generate
        for (s = 0; s < MAX_STAGES; s++)
        begin : g_stage
            if (s < NUM_SLICES)
            begin : g_used
                slice_if sif ();
                logic [SLICE_BITS-1:0] xs; // inverted minuend for borrow
                logic [SLICE_BITS:0] grp_total; // reference slice sum

                assign sif.a = operand_a[s*SLICE_BITS +: SLICE_BITS];
                assign sif.b = operand_b[s*SLICE_BITS +: SLICE_BITS];
                assign sif.subtract = subtract;
                // slice takes the carry of the stage before it
                assign sif.cin = carry[s];
                three_bit_add_slice u_slice (
                    .port(sif)
                );
                assign sum_comb[s*SLICE_BITS +: SLICE_BITS] = sif.sum;
                // each stage pair comes from its own slice
                assign g_all[s] = sif.gg;
                assign p_all[s] = sif.gp;
                // two level sum of products, no ripple
                assign carry[s+1] = lookahead_carry(g_all, p_all,
                    initial_carry_in, s);

                // helper values for the checks below
                assign xs = subtract ? ~sif.a : sif.a;
                assign grp_total = {1'b0, xs} + {1'b0, sif.b}
                    + {{SLICE_BITS{1'b0}}, sif.cin};

                a_bit_generate: assert property (@(posedge clock)
                    disable iff (reset)
                    sif.bit_gen == ((subtract ? ~sif.a : sif.a) & sif.b))
                    else $error("bit generate wrong");
                a_bit_propagate: assert property (@(posedge clock)
                    disable iff (reset)
                    sif.bit_prop == ((subtract ? ~sif.a : sif.a) | sif.b))
                    else $error("bit propagate wrong");
                a_group_propagate: assert property (@(posedge clock)
                    disable iff (reset)
                    sif.gp == (|sif.bit_prop))
                    else $error("group propagate wrong");
                a_group_generate: assert property (@(posedge clock)
                    disable iff (reset)
                    sif.gg == (({1'b0, xs} + {1'b0, sif.b}) >> SLICE_BITS))
                    else $error("group generate wrong");
                a_slice_sum: assert property (@(posedge clock)
                    disable iff (reset)
                    sif.sum == (grp_total[SLICE_BITS-1:0]
                        ^ {SLICE_BITS{subtract}}))
                    else $error("slice sum wrong");
            end
            else
            begin : g_unused
                // unused stages neither generate nor propagate
                assign g_all[s] = 1'b0;
                assign p_all[s] = 1'b0;
            end
        end

        // leftover bits: plain adder fed by the last stage
        if (REM_BITS > 0)
        begin : g_rem
            logic [REM_BITS-1:0] x_rem; // inverted minuend for borrow
            logic [REM_BITS:0] rem_total; // ordinary adder result

            assign x_rem = subtract ? ~operand_a[WIDTH-1 -: REM_BITS]
                : operand_a[WIDTH-1 -: REM_BITS];
            assign rem_total = {1'b0, x_rem}
                + {1'b0, operand_b[WIDTH-1 -: REM_BITS]}
                + {{REM_BITS{1'b0}}, carry[NUM_SLICES]};
            // inverted sum of the borrow form is the difference
            assign sum_comb[WIDTH-1 -: REM_BITS] = rem_total[REM_BITS-1:0]
                ^ {REM_BITS{subtract}};
            assign cout_comb = rem_total[REM_BITS];
        end
        else
        begin : g_norem
            // multiple of three: last stage is the carry out
            assign cout_comb = carry[NUM_SLICES];
        end

        if (NUM_SLICES >= 1)
        begin : g_chk1
            a_first_stage: assert property (@(posedge clock)
                disable iff (reset)
                carry[1] == (g_all[0] | (p_all[0] & initial_carry_in)))
                else $error("first stage carry wrong");
        end
        if (NUM_SLICES >= 2)
        begin : g_chk2
            a_second_stage: assert property (@(posedge clock)
                disable iff (reset)
                carry[2] == (g_all[1] | (p_all[1] & g_all[0])
                    | (p_all[1] & p_all[0] & initial_carry_in)))
                else $error("second stage carry wrong");
        end
    endgenerate

    // next values of the output registers
    always_comb
    begin
        result_d = sum_comb;
        carry_out_d = cout_comb;
    end

    // outputs come from flops; one cycle from operands to result
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            result_q <= '0;
            carry_out_q <= CARRY_RESET;
        end
        else
        begin
            result_q <= result_d;
            carry_out_q <= carry_out_d;
        end
    end

    // registered carry tracks the chain end one cycle later
    a_carry_out: assert property (@(posedge clock) disable iff (reset)
        1'b1 |=> carry_out_q == $past(cout_comb))
        else $error("carry out not registered");
    a_result_hold: assert property (@(posedge clock) disable iff (reset)
        $stable(operand_a) && $stable(operand_b) && $stable(subtract)
        && $stable(initial_carry_in) |=> $stable(result_q) || $past(reset, 2))
        else $error("result changed with stable inputs");
endmodule
`default_nettype wire

// ### user_logic.sv
// operand source standing in for the surrounding user logic
`timescale 1ns/10ps
`default_nettype none
module user_logic #(
    parameter int WIDTH = 14
) (
    input wire logic clock,
    input wire logic nxt_reset,
    input wire logic [WIDTH-1:0] nxt_a,
    input wire logic [WIDTH-1:0] nxt_b,
    input wire logic nxt_c,
    input wire logic nxt_s,
    output var logic reset,
    output var logic [WIDTH-1:0] operand_a,
    output var logic [WIDTH-1:0] operand_b,
    output var logic initial_carry_in,
    output var logic subtract
);
    // known levels from time zero, reset held until told otherwise
    initial
    begin
        reset = 1'b1;
        {operand_a, operand_b, initial_carry_in, subtract} = '0;
    end
    // change on the falling edge, half a cycle clear of capture
    always @(negedge clock)
    begin
        reset <= nxt_reset;
        operand_a <= nxt_a;
        operand_b <= nxt_b;
        initial_carry_in <= nxt_c;
        subtract <= nxt_s;
    end
endmodule
`default_nettype wire

// ### carry_lookahead_add_sub_test.sv
// self-checking bench for the carry lookahead adder and subtractor
`timescale 1ns/10ps
`default_nettype none
module carry_lookahead_add_sub_test;
    import cla_pkg::*;
    localparam int W = DEFAULT_WIDTH;
    logic clock = 1'b0; // 100 MHz
    logic reset, carry_out_q, initial_carry_in, subtract; // dut pins
    logic [W-1:0] operand_a, operand_b, result_q;
    logic nxt_reset = 1'b1; // values the source applies next
    logic nxt_c = 1'b0;
    logic nxt_s = 1'b0;
    logic [W-1:0] nxt_a = '0;
    logic [W-1:0] nxt_b = '0;
    logic [W:0] expected[$]; // oldest note first
    logic [W:0] got, want;
    logic [6:0] expected6[$]; // notes for the six bit instance
    logic [6:0] got6, want6;
    logic [5:0] result6; // six bit instance outputs
    logic carry6;
    int n_mismatch = 0;
    int tests_run = 0;

    carry_lookahead_add_sub #(.WIDTH(W)) dut (.clock(clock), .reset(reset),
        .operand_a(operand_a), .operand_b(operand_b),
        .initial_carry_in(initial_carry_in), .subtract(subtract),
        .result_q(result_q), .carry_out_q(carry_out_q));
    user_logic #(.WIDTH(W)) source (.clock(clock), .nxt_reset(nxt_reset),
        .nxt_a(nxt_a), .nxt_b(nxt_b), .nxt_c(nxt_c), .nxt_s(nxt_s),
        .reset(reset), .operand_a(operand_a), .operand_b(operand_b),
        .initial_carry_in(initial_carry_in), .subtract(subtract));
    // six bit build: two slices, carry out straight from the second stage
    carry_lookahead_add_sub #(.WIDTH(6)) dut6 (.clock(clock), .reset(reset),
        .operand_a(operand_a[5:0]), .operand_b(operand_b[5:0]),
        .initial_carry_in(initial_carry_in), .subtract(subtract),
        .result_q(result6), .carry_out_q(carry6));

    // free running clock, 10 ns period
    initial
    begin
        forever #5 clock = ~clock;
    end

    // reference: slices with or-of-all group propagate, group carries rippled slice to slice
    function automatic logic [W:0] model(logic [W-1:0] a, b, logic c, s,
        int n);
        logic [W-1:0] x, r;
        logic [3:0] t;
        logic g, p;
        r = '0;
        x = s ? ~a : a; // borrow form works on the inverted minuend
        for (int k = 0; k < n / 3; k++)
        begin
            t = {1'b0, x[3*k+:3]} + {1'b0, b[3*k+:3]} + {3'b0, c};
            r[3*k+:3] = t[2:0];
            t = {1'b0, x[3*k+:3]} + {1'b0, b[3*k+:3]};
            g = t[3]; // carry in left out
            p = |(x[3*k+:3] | b[3*k+:3]);
            c = g | (p & c);
        end
        // leftover bits ripple from the last stage carry
        for (int i = 3 * (n / 3); i < n; i++)
        begin
            r[i] = x[i] ^ b[i] ^ c;
            c = (x[i] & b[i]) | ((x[i] | b[i]) & c);
        end
        return {c, s ? ~r : r};
    endfunction

    // one operation per cycle; the note is taken one cycle later
    task automatic apply(input logic [W-1:0] a, b, input logic c, s, rst);
        logic [W:0] m;
        @(posedge clock);
        #2;
        nxt_a = a;
        nxt_b = b;
        nxt_c = c;
        nxt_s = s;
        nxt_reset = rst;
        m = model(a, b, c, s, W);
        expected.push_back(rst ? {CARRY_RESET, {W{1'b0}}} : m);
        m = model(a, b, c, s, 6);
        expected6.push_back(rst ? {CARRY_RESET, 6'h00} : {m[W], m[5:0]});
    endtask

    task automatic end_sim();
        if (n_mismatch == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // watcher: registered result appears just after each rising edge
    initial
    begin
        forever
        begin
            @(posedge clock);
            #1;
            if (expected.size() > 0)
            begin
                got = {carry_out_q, result_q};
                want = expected.pop_front();
                got6 = {carry6, result6};
                want6 = expected6.pop_front();
                tests_run++;
                if (got !== want)
                begin
                    n_mismatch++;
                    $display("Error at %0t: got %h expected %h", $time, got,
                        want);
                end
                if (got6 !== want6)
                begin
                    n_mismatch++;
                    $display("Error at %0t: got %h expected %h", $time, got6,
                        want6);
                end
            end
        end
    end

    initial
    begin
        void'($urandom(37601));
        repeat (20) apply('0, '0, 1'b0, 1'b0, 1'b1);
        apply(14'h0001, 14'h0000, 1'b1, 1'b0, 1'b0);
        apply(14'h0007, 14'h0001, 1'b0, 1'b0, 1'b0);
        apply(14'h0038, 14'h0008, 1'b0, 1'b0, 1'b0);
        apply(14'h003f, 14'h0000, 1'b1, 1'b0, 1'b0);
        apply(14'h0fff, 14'h0001, 1'b0, 1'b0, 1'b0);
        apply(14'h3fff, 14'h3fff, 1'b1, 1'b0, 1'b0);
        apply(14'h0000, 14'h0001, 1'b0, 1'b1, 1'b0);
        apply(14'h1234, 14'h1234, 1'b1, 1'b1, 1'b0);
        apply(14'h2aaa, 14'h1555, 1'b1, 1'b0, 1'b1); // mid-run reset
        apply(14'h2aaa, 14'h1555, 1'b1, 1'b1, 1'b0);
        repeat (600) apply(W'($urandom()), W'($urandom()), 1'($urandom()),
            1'($urandom()), 1'b0);
        // bounded drain of the last notes
        for (int i = 0; i < 10 && expected.size() > 0; i++) @(posedge clock);
        #2;
        if (expected.size() > 0)
            n_mismatch++;
        end_sim();
    end
endmodule
`default_nettype wire
